// ---- src/sbt_pkg.sv ----
// Shared constants, encodings and carrier types of the sixteen-bit timer
package sbt_pkg;

	// ******************************
	// Widths
	// ******************************
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned PRE_W = 10;
	localparam int unsigned FILT_LEN = 4;

	// ******************************
	// Register offsets
	// ******************************
	localparam logic [3:0] OFF_CTRL_A = 4'h0;
	localparam logic [3:0] OFF_CTRL_B = 4'h1;
	localparam logic [3:0] OFF_CTRL_C = 4'h2;
	localparam logic [3:0] OFF_POWER = 4'h3;
	localparam logic [3:0] OFF_CNT_L = 4'h4;
	localparam logic [3:0] OFF_CNT_H = 4'h5;
	localparam logic [3:0] OFF_CMPA_L = 4'h6;
	localparam logic [3:0] OFF_CMPA_H = 4'h7;
	localparam logic [3:0] OFF_CMPB_L = 4'h8;
	localparam logic [3:0] OFF_CMPB_H = 4'h9;
	localparam logic [3:0] OFF_CAP_L = 4'hA;
	localparam logic [3:0] OFF_CAP_H = 4'hB;
	localparam logic [3:0] OFF_FLAG = 4'hC;
	localparam logic [3:0] OFF_MASK = 4'hD;
	localparam logic [3:0] OFF_CLEAR = 4'hE;

	// ******************************
	// Field positions
	// ******************************
	localparam int unsigned A_WGM_LSB = 0;
	localparam int unsigned A_OUTB_EN = 5;
	localparam int unsigned A_OUTA_EN = 7;
	localparam int unsigned B_CS_LSB = 0;
	localparam int unsigned B_WGM_LSB = 3;
	localparam int unsigned B_EDGE = 6;
	localparam int unsigned B_FILT = 7;
	localparam int unsigned C_FORCE_B = 6;
	localparam int unsigned C_FORCE_A = 7;
	localparam int unsigned P_GATE = 0;
	localparam int unsigned F_OVF = 0;
	localparam int unsigned F_MA = 1;
	localparam int unsigned F_MB = 2;
	localparam int unsigned F_CAP = 3;
	localparam int unsigned N_FLAGS = 4;

	// ******************************
	// Reset values and fixed counts
	// ******************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_POWER = 8'h01;
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_64 = 10'h03F;
	localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

	// ******************************
	// Encodings
	// ******************************
	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} sbt_clk_sel_t;

	localparam logic [3:0] WGM_NORMAL = 4'h0;
	localparam logic [3:0] WGM_CTC_A = 4'h4;
	localparam logic [3:0] WGM_PWM8 = 4'h5;
	localparam logic [3:0] WGM_PWM9 = 4'h6;
	localparam logic [3:0] WGM_PWM10 = 4'h7;
	localparam logic [3:0] WGM_CTC_CAP = 4'hC;
	localparam logic [3:0] WGM_PWM_CAP = 4'hE;
	localparam logic [3:0] WGM_PWM_A = 4'hF;

	// ******************************
	// Carriers
	// ******************************
	typedef struct packed {
		logic [3:0] mode;
		sbt_clk_sel_t cs;
		logic edge_rise;
		logic filt_on;
		logic out_a_en;
		logic out_b_en;
	} sbt_cfg_t;

	typedef struct packed {
		logic a;
		logic b;
	} sbt_wave_t;

endpackage

// ---- src/sbt_pin_filter.sv ----
// Pin synchroniser with optional noise filter for timer inputs
`timescale 1ns/100ps
module sbt_pin_filter import sbt_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic filt_on,
	output logic level
);

	logic sync1_r;
	logic sync2_r;
	logic [FILT_LEN-1:0] hist_r;
	logic [FILT_LEN-1:0] hist_nxt;
	logic level_r;
	logic level_nxt;

	// ******************************
	// Filter
	// ******************************
	// With the filter on, level only moves after FILT_LEN equal samples, costing that much latency
	always_comb begin
		hist_nxt = {hist_r[FILT_LEN-2:0], sync2_r};
		level_nxt = level_r;
		if (!filt_on) begin
			level_nxt = sync2_r;
		end else if (&hist_r) begin
			level_nxt = 1'b1;
		end else if (~|hist_r) begin
			level_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			hist_r <= '0;
			level_r <= 1'b0;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
			hist_r <= hist_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;

endmodule

// ---- src/sbt_timer.sv ----
// Sixteen-bit timer with compare, capture and shared high-byte access
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module sbt_timer import sbt_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic external_count_pin,
	input wire logic capture_input_pin,
	output sbt_wave_t wave,
	output logic irq
);

	// ******************************
	// Decoding functions
	// ******************************
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m == WGM_PWM8) || (m == WGM_PWM9) || (m == WGM_PWM10) ||
			(m == WGM_PWM_CAP) || (m == WGM_PWM_A);
	endfunction

	function automatic logic cap_is_top(input logic [3:0] m);
		cap_is_top = (m == WGM_CTC_CAP) || (m == WGM_PWM_CAP);
	endfunction

	function automatic logic a_is_top(input logic [3:0] m);
		a_is_top = (m == WGM_CTC_A) || (m == WGM_PWM_A);
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
		input logic [15:0] c);
		case (m)
			WGM_PWM8: top_of = TOP_8BIT;
			WGM_PWM9: top_of = TOP_9BIT;
			WGM_PWM10: top_of = TOP_10BIT;
			WGM_CTC_A, WGM_PWM_A: top_of = a;
			WGM_CTC_CAP, WGM_PWM_CAP: top_of = c;
			default: top_of = MAX_VAL;
		endcase
	endfunction

	function automatic logic pre_tap(input logic [9:0] p, input logic [9:0] mask);
		pre_tap = (p & mask) == mask;
	endfunction

	// ******************************
	// State
	// ******************************
	logic [7:0] ctrl_a_r, ctrl_a_nxt;
	logic [7:0] ctrl_b_r, ctrl_b_nxt;
	logic gate_r, gate_nxt;
	logic [N_FLAGS-1:0] flags_r, flags_nxt;
	logic [N_FLAGS-1:0] mask_r, mask_nxt;
	logic [7:0] temp_r, temp_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] cmpa_buf_r, cmpa_buf_nxt;
	logic [15:0] cmpb_buf_r, cmpb_buf_nxt;
	logic [15:0] cmpa_r, cmpa_nxt;
	logic [15:0] cmpb_r, cmpb_nxt;
	logic [15:0] cap_r, cap_nxt;
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic ext_prev_r;
	logic cap_prev_r;
	logic [7:0] rdata_r, rdata_nxt;
	sbt_wave_t wave_r, wave_nxt;

	sbt_cfg_t cfg;
	logic ext_lvl;
	logic cap_lvl;
	logic timer_tick;
	logic [15:0] top;
	logic at_top;
	logic match_a;
	logic match_b;
	logic cap_edge;
	logic pwm;

	// ******************************
	// Pin conditioning
	// ******************************
	sbt_pin_filter u_ext (
		.clock(clock),
		.rst_n(rst_n),
		.pin(external_count_pin),
		.filt_on(1'b0),
		.level(ext_lvl)
	);

	sbt_pin_filter u_cap (
		.clock(clock),
		.rst_n(rst_n),
		.pin(capture_input_pin),
		.filt_on(cfg.filt_on),
		.level(cap_lvl)
	);

	// ******************************
	// Configuration and clock select
	// ******************************
	always_comb begin
		cfg.mode = {ctrl_b_r[B_WGM_LSB+1:B_WGM_LSB], ctrl_a_r[A_WGM_LSB+1:A_WGM_LSB]};
		cfg.cs = sbt_clk_sel_t'(ctrl_b_r[B_CS_LSB+2:B_CS_LSB]);
		cfg.edge_rise = ctrl_b_r[B_EDGE];
		cfg.filt_on = ctrl_b_r[B_FILT];
		cfg.out_a_en = ctrl_a_r[A_OUTA_EN];
		cfg.out_b_en = ctrl_a_r[A_OUTB_EN];
	end

	always_comb begin
		case (cfg.cs)
			CS_DIV1: timer_tick = 1'b1;
			CS_DIV8: timer_tick = pre_tap(pre_r, PRE_MASK_8);
			CS_DIV64: timer_tick = pre_tap(pre_r, PRE_MASK_64);
			CS_DIV256: timer_tick = pre_tap(pre_r, PRE_MASK_256);
			CS_DIV1024: timer_tick = pre_tap(pre_r, PRE_MASK_1024);
			CS_EXT_FALL: timer_tick = ext_prev_r & ~ext_lvl;
			CS_EXT_RISE: timer_tick = ~ext_prev_r & ext_lvl;
			default: timer_tick = 1'b0;
		endcase
		if (gate_r) begin
			timer_tick = 1'b0;
		end
	end

	// ******************************
	// Counter, compare and capture
	// ******************************
	assign pwm = is_pwm(cfg.mode);
	assign top = top_of(cfg.mode, cmpa_r, cap_r);
	assign at_top = cnt_r == top;
	assign match_a = timer_tick && (cnt_r == cmpa_r);
	assign match_b = timer_tick && (cnt_r == cmpb_r);
	assign cap_edge = cfg.edge_rise ? (~cap_prev_r & cap_lvl) : (cap_prev_r & ~cap_lvl);

	always_comb begin
		cnt_nxt = cnt_r;
		cmpa_nxt = cmpa_r;
		cmpb_nxt = cmpb_r;
		cap_nxt = cap_r;
		cmpa_buf_nxt = cmpa_buf_r;
		cmpb_buf_nxt = cmpb_buf_r;
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		gate_nxt = gate_r;
		mask_nxt = mask_r;
		flags_nxt = flags_r;
		temp_nxt = temp_r;
		rdata_nxt = RST_BYTE;
		wave_nxt = wave_r;
		pre_nxt = (gate_r || cfg.cs == CS_STOP) ? '0 : PRE_W'(pre_r + 1'b1);
		if (timer_tick) begin
			cnt_nxt = at_top ? BOTTOM_VAL : 16'(cnt_r + 1'b1);
		end
		// Buffered compares load at top in PWM so a period never sees a torn value
		if (!pwm) begin
			cmpa_nxt = cmpa_buf_r;
			cmpb_nxt = cmpb_buf_r;
		end else if (timer_tick && at_top) begin
			cmpa_nxt = cmpa_buf_r;
			cmpb_nxt = cmpb_buf_r;
		end
		if (cap_edge && !gate_r && !cap_is_top(cfg.mode)) begin
			cap_nxt = cnt_r;
		end
		// Waveforms: PWM sets at top (A stays low when compare A is top), clears on match; other modes toggle on match
		if (pwm) begin
			if (timer_tick && at_top) begin
				wave_nxt.a = cfg.out_a_en && !a_is_top(cfg.mode);
				wave_nxt.b = cfg.out_b_en;
			end
			if (match_a) begin
				wave_nxt.a = 1'b0;
			end
			if (match_b) begin
				wave_nxt.b = 1'b0;
			end
		end else begin
			if (cfg.out_a_en && (match_a || (wr && addr == OFF_CTRL_C && wdata[C_FORCE_A]))) begin
				wave_nxt.a = ~wave_r.a;
			end
			if (cfg.out_b_en && (match_b || (wr && addr == OFF_CTRL_C && wdata[C_FORCE_B]))) begin
				wave_nxt.b = ~wave_r.b;
			end
		end

		// Bus writes; clears are applied before sets so an event never gets lost
		if (wr) begin
			case (addr)
				OFF_CTRL_A: ctrl_a_nxt = wdata;
				OFF_CTRL_B: ctrl_b_nxt = wdata;
				OFF_POWER: gate_nxt = wdata[P_GATE];
				OFF_CNT_H, OFF_CMPA_H, OFF_CMPB_H, OFF_CAP_H: temp_nxt = wdata;
				OFF_CNT_L: cnt_nxt = {temp_r, wdata};
				OFF_CMPA_L: cmpa_buf_nxt = {temp_r, wdata};
				OFF_CMPB_L: cmpb_buf_nxt = {temp_r, wdata};
				OFF_CAP_L: cap_nxt = {temp_r, wdata};
				OFF_MASK: mask_nxt = wdata[N_FLAGS-1:0];
				OFF_CLEAR: flags_nxt = flags_r & ~wdata[N_FLAGS-1:0];
				default: ;
			endcase
		end

		// Bus reads; answer stands for exactly one cycle
		if (rd) begin
			case (addr)
				OFF_CTRL_A: rdata_nxt = ctrl_a_r;
				OFF_CTRL_B: rdata_nxt = ctrl_b_r;
				OFF_POWER: rdata_nxt = {7'h00, gate_r};
				OFF_CNT_L: begin
					rdata_nxt = cnt_r[7:0];
					temp_nxt = cnt_r[15:8];
				end
				OFF_CAP_L: begin
					rdata_nxt = cap_r[7:0];
					temp_nxt = cap_r[15:8];
				end
				OFF_CNT_H, OFF_CAP_H: rdata_nxt = temp_r;
				OFF_CMPA_L: rdata_nxt = cmpa_buf_r[7:0];
				OFF_CMPA_H: rdata_nxt = cmpa_buf_r[15:8];
				OFF_CMPB_L: rdata_nxt = cmpb_buf_r[7:0];
				OFF_CMPB_H: rdata_nxt = cmpb_buf_r[15:8];
				OFF_FLAG: rdata_nxt = {4'h0, flags_r};
				OFF_MASK: rdata_nxt = {4'h0, mask_r};
				default: rdata_nxt = RST_BYTE;
			endcase
		end

		// Flag sets, in PWM overflow marks top, otherwise the wrap from max
		if (timer_tick && (pwm ? at_top : (cnt_r == MAX_VAL))) begin
			flags_nxt[F_OVF] = 1'b1;
		end
		if (match_a) begin
			flags_nxt[F_MA] = 1'b1;
		end
		if (match_b) begin
			flags_nxt[F_MB] = 1'b1;
		end
		if (cap_edge && !gate_r && !cap_is_top(cfg.mode)) begin
			flags_nxt[F_CAP] = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_r <= RST_BYTE;
			ctrl_b_r <= RST_BYTE;
			gate_r <= RST_POWER[P_GATE];
			flags_r <= '0;
			mask_r <= '0;
			temp_r <= RST_BYTE;
			cnt_r <= BOTTOM_VAL;
			cmpa_buf_r <= BOTTOM_VAL;
			cmpb_buf_r <= BOTTOM_VAL;
			cmpa_r <= BOTTOM_VAL;
			cmpb_r <= BOTTOM_VAL;
			cap_r <= BOTTOM_VAL;
			pre_r <= '0;
			ext_prev_r <= 1'b0;
			cap_prev_r <= 1'b0;
			rdata_r <= RST_BYTE;
			wave_r <= '0;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			gate_r <= gate_nxt;
			flags_r <= flags_nxt;
			mask_r <= mask_nxt;
			temp_r <= temp_nxt;
			cnt_r <= cnt_nxt;
			cmpa_buf_r <= cmpa_buf_nxt;
			cmpb_buf_r <= cmpb_buf_nxt;
			cmpa_r <= cmpa_nxt;
			cmpb_r <= cmpb_nxt;
			cap_r <= cap_nxt;
			pre_r <= pre_nxt;
			ext_prev_r <= ext_lvl;
			cap_prev_r <= cap_lvl;
			rdata_r <= rdata_nxt;
			wave_r <= wave_nxt;
		end
	end

	// ******************************
	// Outputs
	// ******************************
	assign rdata = rdata_r;
	assign wave = wave_r;
	assign irq = |(flags_r & mask_r);

endmodule

// ---- dv/sbt_timer_assertions.sv ----
// Port checker of the sixteen-bit timer
`timescale 1ns/100ps
module sbt_timer_chk import sbt_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic external_count_pin,
	input wire logic capture_input_pin,
	input wire sbt_wave_t wave,
	input wire logic irq
);
	// ****************
	// Shadow of software writes
	// ****************
	// Temp is unknown after a counter or capture low read, so ok bits gate its checks
	typedef struct packed {
		logic [7:0] tmp;
		logic tmp_ok;
		logic [15:0] ca;
		logic ca_ok;
		logic [3:0] mask;
		logic gate;
	} sbt_shadow_t;
	sbt_shadow_t sh_r;
	sbt_shadow_t sh_nxt;
	always_comb begin
		sh_nxt = sh_r;
		if (wr) begin
			case (addr)
				OFF_CNT_H, OFF_CMPA_H, OFF_CMPB_H, OFF_CAP_H: begin
					sh_nxt.tmp = wdata;
					sh_nxt.tmp_ok = 1'b1;
				end
				OFF_CMPA_L: begin
					sh_nxt.ca = {sh_r.tmp, wdata};
					sh_nxt.ca_ok = sh_r.tmp_ok;
				end
				OFF_MASK: sh_nxt.mask = wdata[3:0];
				OFF_POWER: sh_nxt.gate = wdata[P_GATE];
				default: ;
			endcase
		end
		if (rd && (addr == OFF_CNT_L || addr == OFF_CAP_L)) begin
			sh_nxt.tmp_ok = 1'b0;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= '{8'h00, 1'b0, 16'h0000, 1'b1, 4'h0, 1'b1};
		end else begin
			sh_r <= sh_nxt;
		end
	end
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_cmpa_low_read:
		assert property (rd && addr == OFF_CMPA_L && sh_r.ca_ok |=> rdata == sh_r.ca[7:0])
		else $error("compare A low byte wrong");
	a_cmpa_high_read:
		assert property (rd && addr == OFF_CMPA_H && sh_r.ca_ok |=> rdata == sh_r.ca[15:8])
		else $error("compare A high byte wrong");
	a_temp_high_read:
		assert property (rd && (addr == OFF_CNT_H || addr == OFF_CAP_H) && sh_r.tmp_ok
			|=> rdata == sh_r.tmp)
		else $error("high byte read not from temp");
	a_mask_read_back:
		assert property (rd && addr == OFF_MASK |=> rdata[3:0] == sh_r.mask)
		else $error("mask read back wrong");
	a_irq_needs_mask:
		assert property (sh_r.mask == 4'h0 |-> !irq)
		else $error("irq with all masked");
	a_irq_has_flag:
		assert property (rd && addr == OFF_FLAG && irq |=> (rdata[3:0] & sh_r.mask) != 4'h0)
		else $error("irq without enabled flag");
	a_gate_read_back:
		assert property (rd && addr == OFF_POWER |=> rdata[P_GATE] == sh_r.gate)
		else $error("power gate read wrong");
	a_gated_quiet:
		assert property (sh_r.gate && $past(sh_r.gate) && $past(sh_r.gate, 2)
			&& !(wr && addr == OFF_MASK) |=> !$rose(irq))
		else $error("event while gated");
endmodule

bind sbt_timer sbt_timer_chk u_chk (.clock(clock), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(external_count_pin),
	.capture_input_pin(capture_input_pin), .wave(wave), .irq(irq));

// ---- dv/sbt_cpu_model.sv ----
// CPU bus master model for the timer register port
`timescale 1ns/100ps
module sbt_cpu_model import sbt_pkg::*; (
	input wire logic clock,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [DATA_W-1:0] rdata
);
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic write8(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Data is taken mid-cycle, clear of the edge that launches it
	task automatic read8(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask
	task automatic write16(input logic [ADDR_W-1:0] lo, input logic [15:0] v);
		write8(lo + 4'h1, v[15:8]);
		write8(lo, v[7:0]);
	endtask
	task automatic read16(input logic [ADDR_W-1:0] lo, output logic [15:0] v);
		read8(lo, v[7:0]);
		read8(lo + 4'h1, v[15:8]);
	endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench of the sixteen-bit timer
`timescale 1ns/100ps
module tb import sbt_pkg::*; ;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ext_pin = 1'b0;
	logic cap_pin = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic wr;
	logic rd;
	logic irq;
	sbt_wave_t wave;
	logic [15:0] v;
	logic [7:0] f;
	logic [15:0] tops [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #5 clock = ~clock;
	sbt_timer DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
		.wave(wave), .irq(irq));
	sbt_cpu_model cpu (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Longest scenario is the 10-bit top sweep, well under this ceiling
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		cpu.read8(a, f);
		check({8'h00, f}, {8'h00, e});
	endtask
	task automatic rd16_chk(input logic [3:0] a, input logic [15:0] e);
		cpu.read16(a, v);
		check(v, e);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge clock);
		check({15'h0000, irq}, {15'h0000, e});
	endtask
	task automatic chk_wave(input logic [1:0] e);
		@(negedge clock);
		check({14'h0000, wave}, {14'h0000, e});
	endtask
	task automatic run(input logic [7:0] b, input int n);
		cpu.write8(OFF_CTRL_B, b);
		ticks(n);
		cpu.write8(OFF_CTRL_B, b & 8'hF8);
	endtask
	task automatic t_reset;
		rd_chk(OFF_POWER, RST_POWER);
		rd_chk(OFF_MASK, 8'h00);
		rd_chk(OFF_FLAG, 8'h00);
		chk_irq(1'b0);
	endtask
	task automatic t_access;
		cpu.write16(OFF_CMPA_L, 16'h1234);
		rd16_chk(OFF_CMPA_L, 16'h1234);
		cpu.write8(OFF_CNT_H, 8'hAB);
		cpu.write8(OFF_CMPA_L, 8'h11);
		cpu.write8(OFF_CMPB_L, 8'h22);
		rd16_chk(OFF_CMPA_L, 16'hAB11);
		rd16_chk(OFF_CMPB_L, 16'hAB22);
		cpu.write16(OFF_CNT_L, 16'h01FF);
		cpu.write8(OFF_CNT_H, 8'h5A);
		rd_chk(OFF_CNT_H, 8'h5A);
		rd_chk(OFF_CNT_L, 8'hFF);
		rd_chk(OFF_CMPA_H, 8'hAB);
		rd_chk(OFF_CNT_H, 8'h01);
	endtask
	task automatic t_gate;
		run(8'h01, 20);
		rd16_chk(OFF_CNT_L, 16'h01FF);
		cpu.write16(OFF_CNT_L, 16'h0000);
		cpu.write8(OFF_POWER, 8'h00);
		cpu.write8(OFF_CTRL_B, 8'h07);
		repeat (5) begin
			@(posedge clock);
			ext_pin <= 1'b1;
			ticks(4);
			ext_pin <= 1'b0;
			ticks(4);
		end
		run(8'h07, 4);
		rd16_chk(OFF_CNT_L, 16'h0005);
	endtask
	task automatic t_events;
		cpu.write16(OFF_CNT_L, 16'hFFF0);
		cpu.write8(OFF_CLEAR, 8'h0F);
		cpu.write8(OFF_MASK, 8'h01);
		run(8'h01, 30);
		chk_irq(1'b1);
		rd_chk(OFF_FLAG, 8'h01);
		cpu.write8(OFF_MASK, 8'h00);
		chk_irq(1'b0);
		cpu.write8(OFF_MASK, 8'h01);
		cpu.write8(OFF_CLEAR, 8'h01);
		chk_irq(1'b0);
		cpu.write16(OFF_CMPA_L, 16'h0010);
		cpu.write16(OFF_CMPB_L, 16'h0020);
		cpu.write16(OFF_CNT_L, 16'h0000);
		cpu.write8(OFF_CLEAR, 8'h0F);
		run(8'h01, 50);
		rd_chk(OFF_FLAG, 8'h06);
		cpu.write16(OFF_CNT_L, 16'h4321);
		cpu.write8(OFF_CLEAR, 8'h0F);
		cpu.write8(OFF_CTRL_B, 8'h40);
		@(posedge clock);
		cap_pin <= 1'b1;
		ticks(10);
		rd_chk(OFF_FLAG, 8'h08);
		rd16_chk(OFF_CAP_L, 16'h4321);
	endtask
	task automatic t_top;
		for (int i = 0; i < 3; i++) begin
			cpu.write16(OFF_CNT_L, 16'h0000);
			cpu.write8(OFF_CLEAR, 8'h0F);
			cpu.write8(OFF_CTRL_A, 8'(i + 1));
			run(8'h09, int'(tops[i]) + 10);
			cpu.read16(OFF_CNT_L, v);
			check({15'h0000, v <= tops[i]}, 16'h0001);
			cpu.read8(OFF_FLAG, f);
			check({15'h0000, f[F_OVF]}, 16'h0001);
		end
	endtask
	// Waveforms, compare A as top, prescaler tap and filtered capture
	task automatic t_wave;
		cpu.write8(OFF_CTRL_B, 8'h00);
		cpu.write8(OFF_CTRL_A, 8'hA0);
		cpu.write16(OFF_CMPA_L, 16'h0005);
		cpu.write16(OFF_CNT_L, 16'h0000);
		cpu.write8(OFF_CLEAR, 8'h0F);
		run(8'h01, 20);
		chk_wave(2'b10);
		cpu.write8(OFF_CTRL_C, 8'h40);
		chk_wave(2'b11);
		rd_chk(OFF_FLAG, 8'h02);
		cpu.write8(OFF_CTRL_A, 8'hA3);
		cpu.write16(OFF_CMPA_L, 16'h0008);
		cpu.write16(OFF_CMPB_L, 16'h0004);
		cpu.write16(OFF_CNT_L, 16'h0000);
		cpu.write8(OFF_CLEAR, 8'h0F);
		run(8'h19, 30);
		cpu.read16(OFF_CNT_L, v);
		check({15'h0000, v <= 16'h0008}, 16'h0001);
		check({15'h0000, wave.a}, 16'h0000);
		rd_chk(OFF_FLAG, 8'h07);
		cpu.write8(OFF_CTRL_A, 8'h00);
		cpu.write16(OFF_CNT_L, 16'h0000);
		run(8'h02, 80);
		rd16_chk(OFF_CNT_L, 16'h000A);
		cpu.write16(OFF_CNT_L, 16'h0777);
		cpu.write8(OFF_CLEAR, 8'h0F);
		cpu.write8(OFF_CTRL_B, 8'h80);
		@(posedge clock);
		cap_pin <= 1'b0;
		ticks(2);
		cap_pin <= 1'b1;
		ticks(12);
		rd_chk(OFF_FLAG, 8'h00);
		@(posedge clock);
		cap_pin <= 1'b0;
		ticks(12);
		rd_chk(OFF_FLAG, 8'h08);
		rd16_chk(OFF_CAP_L, 16'h0777);
	endtask
	initial begin
		ticks(12);
		rst_n <= 1'b1;
		t_reset();
		t_access();
		t_gate();
		t_events();
		t_top();
		t_wave();
		tally_and_finish();
	end
endmodule
